// *** hdl/aic_defs.svh ***
/*
 * Constants of the analog input conditioning block: scales, field widths,
 * reset values and timing counts.
 * Assumes inclusion from the package and from the top module only.
 */
// Notes on behaviour
// (R1) sum of input and offset, times gain
// (R2) negative speed reference reverses, magnitude used
// (R3) torque limit input clamps negatives to zero
// (R4) first-order filter, time constant 0 to 16 s
// (R5) codes 0 to 3 everywhere, 4 bipolar two/four
// (R6) codes 2 and 3 invert the input mapping
// (R7) conditioned value readable as percent monitor
// (R8) conditioned value saturates at plus/minus full scale
`ifndef AIC_DEFS_SVH
`define AIC_DEFS_SVH

// ----------------------------------------------------------------------------
// value scales
// ----------------------------------------------------------------------------
// percent values in 0.01 % units, 10000 is full scale (10 V / 20 mA)
`define AIC_FULL_SCALE 32'sd10000
`define AIC_LIVE_ZERO 32'sd2000
`define AIC_LIVE_SPAN_NUM 32'sd5
`define AIC_LIVE_SPAN_DEN 32'sd4
// gain in 0.001 units, 1000 is unity, 9999 the top
`define AIC_GAIN_ONE 32'sd1000
`define AIC_GAIN_MAX 16'h270f
`define AIC_OFFSET_MAX 16'sh2710

// ----------------------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------------------
`define AIC_NUM_INPUTS 4
`define AIC_WORD_W 16
`define AIC_TYPE_W 3
`define AIC_FUNC_W 3
`define AIC_FRAC_W 16
`define AIC_GAIN_RST 16'h03e8
`define AIC_OFFSET_RST 16'h0000
`define AIC_FILTER_RST 16'h0000
`define AIC_TYPE_RST 3'h0
`define AIC_FUNC_RST 3'h0
// filter time in 0.01 s units, 1600 is 16.00 s
`define AIC_FILTER_MAX 16'h0640

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define AIC_CLK_HZ 200000000
// each input is filtered once per 1 ms; four inputs share one slot each
`define AIC_FILTER_STEP_US 1000
`define AIC_SLOT_CYCLES ((`AIC_CLK_HZ / 1000000) * `AIC_FILTER_STEP_US / `AIC_NUM_INPUTS)
// filter time unit (10 ms) expressed in filter steps
`define AIC_STEPS_PER_UNIT 10

`endif

// *** hdl/aic_pkg.sv ***
/*
 * Types of the analog input conditioning block.
 * Assumes aic_defs.svh is on the include path.
 */
`include "aic_defs.svh"

package aic_pkg;

    typedef enum logic [2:0] {
        AIC_TYPE_UNI = 3'b000,
        AIC_TYPE_LIVE = 3'b001,
        AIC_TYPE_UNI_INV = 3'b010,
        AIC_TYPE_LIVE_INV = 3'b011,
        AIC_TYPE_BIPOLAR = 3'b100
    } aic_sig_type_t;

    typedef enum logic [2:0] {
        AIC_FUNC_SPEED = 3'b000,
        AIC_FUNC_NO_RAMP = 3'b001,
        AIC_FUNC_TORQUE = 3'b010,
        AIC_FUNC_PROCESS = 3'b011,
        AIC_FUNC_PTC = 3'b100,
        AIC_FUNC_UNUSED5 = 3'b101,
        AIC_FUNC_UNUSED6 = 3'b110,
        AIC_FUNC_PLC = 3'b111
    } aic_func_t;

    // settings of one input, held by the parameter store outside
    typedef struct packed {
        logic [15:0] gain;
        logic signed [15:0] offset;
        logic [15:0] filter_time;
        logic [2:0] signal_type;
        logic [2:0] func;
    } aic_cfg_t;

    // result of one input toward the consumers of the input function
    typedef struct packed {
        logic signed [15:0] value;
        logic reverse;
    } aic_out_t;

endpackage : aic_pkg

// *** hdl/aic_top.sv ***
/*
 * Conditioning of four analog inputs: range decode, offset, gain,
 * saturation, first-order filter and function-specific post-processing.
 * Assumes samples arrive synchronous to sys_clk_i in 0.01 % units of full
 * scale and that settings are held stable by the parameter store outside.
 */
`timescale 1ns/1ps
`include "aic_defs.svh"

module aic_top
    import aic_pkg::*;
#(
    parameter int SLOT_CYCLES = `AIC_SLOT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic signed [15:0] analog_in_one_i,
    input wire logic signed [15:0] analog_in_two_i,
    input wire logic signed [15:0] analog_in_three_i,
    input wire logic signed [15:0] analog_in_four_i,
    input wire aic_cfg_t input1_cfg_i,
    input wire aic_cfg_t input2_cfg_i,
    input wire aic_cfg_t input3_cfg_i,
    input wire aic_cfg_t input4_cfg_i,
    output logic signed [15:0] input1_monitor_o,
    output logic signed [15:0] input2_monitor_o,
    output logic signed [15:0] input3_monitor_o,
    output logic signed [15:0] input4_monitor_o,
    output aic_out_t input1_result_o,
    output aic_out_t input2_result_o,
    output aic_out_t input3_result_o,
    output aic_out_t input4_result_o,
    output logic filter_step_o
);

    localparam int NI = `AIC_NUM_INPUTS;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic signed [31:0] sat_fs(input logic signed [31:0] v);
        if (v > `AIC_FULL_SCALE) begin
            return `AIC_FULL_SCALE; // [R8]
        end else if (v < -`AIC_FULL_SCALE) begin
            return -`AIC_FULL_SCALE; // [R8]
        end else begin
            return v;
        end
    endfunction

    // range decode; code 4 only on inputs two and four, else as code 0 clamped to full scale
    function automatic logic signed [31:0] map_range(input logic signed [15:0] x,
                                                      input logic [2:0] code,
                                                      input logic bip_ok);
        logic signed [31:0] xs;
        logic signed [31:0] live;
        xs = 32'(x);
        live = ((xs - `AIC_LIVE_ZERO) * `AIC_LIVE_SPAN_NUM) / `AIC_LIVE_SPAN_DEN;
        unique case (code)
            AIC_TYPE_LIVE: return live; // [R5]
            AIC_TYPE_UNI_INV: return `AIC_FULL_SCALE - xs; // [R6]
            AIC_TYPE_LIVE_INV: return `AIC_FULL_SCALE - live; // [R6]
            AIC_TYPE_BIPOLAR: return bip_ok ? xs : sat_fs(xs); // [R5]
            default: return xs; // [R5]
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // input gathering
    // ------------------------------------------------------------------------
    logic signed [15:0] raw [NI];
    aic_cfg_t cfg [NI];
    assign raw[0] = analog_in_one_i;
    assign raw[1] = analog_in_two_i;
    assign raw[2] = analog_in_three_i;
    assign raw[3] = analog_in_four_i;
    assign cfg[0] = input1_cfg_i;
    assign cfg[1] = input2_cfg_i;
    assign cfg[2] = input3_cfg_i;
    assign cfg[3] = input4_cfg_i;

    // ------------------------------------------------------------------------
    // offset, gain and saturation
    // ------------------------------------------------------------------------
    logic signed [15:0] cond [NI];
    logic signed [15:0] next_cond [NI];

    always_comb begin
        logic signed [31:0] mapped;
        logic signed [31:0] summed;
        logic signed [47:0] prod;
        logic [15:0] g;
        mapped = '0;
        summed = '0;
        prod = '0;
        g = '0;
        for (int i = 0; i < NI; i++) begin
            next_cond[i] = cond[i];
            if (sample_valid_i) begin
                g = (cfg[i].gain > `AIC_GAIN_MAX) ? `AIC_GAIN_MAX : cfg[i].gain;
                mapped = map_range(raw[i], cfg[i].signal_type, i == 1 || i == 3);
                summed = mapped + 32'(cfg[i].offset); // [R1]
                prod = (48'(summed) * 48'(signed'({1'b0, g}))) / 48'(`AIC_GAIN_ONE); // [R1]
                if (prod > 48'(`AIC_FULL_SCALE)) begin
                    next_cond[i] = 16'(`AIC_FULL_SCALE); // [R8]
                end else if (prod < -48'(`AIC_FULL_SCALE)) begin
                    next_cond[i] = 16'(-`AIC_FULL_SCALE); // [R8]
                end else begin
                    next_cond[i] = prod[15:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < NI; i++) begin
            cond[i] <= rst_i ? 16'h0000 : next_cond[i];
        end
    end

    assign input1_monitor_o = cond[0]; // [R7]
    assign input2_monitor_o = cond[1]; // [R7]
    assign input3_monitor_o = cond[2]; // [R7]
    assign input4_monitor_o = cond[3]; // [R7]

    // ------------------------------------------------------------------------
    // filter slot divider
    // ------------------------------------------------------------------------
    logic [31:0] slot_cnt;
    logic [31:0] next_slot_cnt;
    logic [1:0] slot;
    logic [1:0] next_slot;
    logic step;

    always_comb begin
        step = (slot_cnt == 32'(SLOT_CYCLES - 1));
        next_slot_cnt = step ? 32'h0000_0000 : slot_cnt + 32'h0000_0001;
        next_slot = step ? slot + 2'h1 : slot;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            slot_cnt <= 32'h0000_0000;
            slot <= 2'h0;
        end else begin
            slot_cnt <= next_slot_cnt;
            slot <= next_slot;
        end
    end

    assign filter_step_o = step;

    // ------------------------------------------------------------------------
    // first-order filter, one input per slot, one shared divider
    // ------------------------------------------------------------------------
    // acc holds value scaled by 2^16; y += (x - y) / (tau in 1 ms steps)
    logic signed [31:0] acc [NI];
    logic signed [31:0] next_acc [NI];

    always_comb begin
        logic signed [31:0] target;
        logic signed [31:0] diff;
        logic signed [31:0] steps;
        target = '0;
        diff = '0;
        steps = '0;
        for (int i = 0; i < NI; i++) begin
            next_acc[i] = acc[i];
        end
        if (step) begin
            target = 32'(cond[slot]) <<< `AIC_FRAC_W;
            if (cfg[slot].filter_time == 16'h0000) begin
                next_acc[slot] = target; // [R4]
            end else begin
                steps = (cfg[slot].filter_time > `AIC_FILTER_MAX) ?
                        32'(`AIC_FILTER_MAX) * `AIC_STEPS_PER_UNIT :
                        32'(cfg[slot].filter_time) * `AIC_STEPS_PER_UNIT;
                diff = target - acc[slot];
                next_acc[slot] = acc[slot] + diff / steps; // [R4]
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < NI; i++) begin
            acc[i] <= rst_i ? 32'sh0000_0000 : next_acc[i];
        end
    end

    // ------------------------------------------------------------------------
    // function-specific post-processing
    // ------------------------------------------------------------------------
    aic_out_t res [NI];
    aic_out_t next_res [NI];

    always_comb begin
        logic signed [15:0] y;
        y = '0;
        for (int i = 0; i < NI; i++) begin
            y = acc[i][31:16];
            next_res[i].value = y;
            next_res[i].reverse = 1'b0;
            unique case (cfg[i].func)
                AIC_FUNC_SPEED: begin
                    next_res[i].reverse = y[15]; // [R2]
                    next_res[i].value = y[15] ? -y : y; // [R2]
                end
                AIC_FUNC_TORQUE: begin
                    next_res[i].value = y[15] ? 16'sh0000 : y; // [R3]
                end
                default: begin
                    next_res[i].value = y;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < NI; i++) begin
            res[i] <= rst_i ? '0 : next_res[i];
        end
    end

    assign input1_result_o = res[0];
    assign input2_result_o = res[1];
    assign input3_result_o = res[2];
    assign input4_result_o = res[3];

endmodule // aic_top

// *** test/aic_top_monitor.sv ***
/*
 * Checker of the conditioning block on the top ports.
 * Assumes binding into aic_top; unity gain is 16'h03e8.
 */
`timescale 1ns/1ps

module aic_top_monitor
    import aic_pkg::*;
#(
    parameter int SLOT_CYCLES = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic signed [15:0] analog_in_one_i,
    input wire logic signed [15:0] analog_in_two_i,
    input wire logic signed [15:0] analog_in_three_i,
    input wire aic_cfg_t input1_cfg_i,
    input wire aic_cfg_t input2_cfg_i,
    input wire aic_cfg_t input3_cfg_i,
    input wire logic signed [15:0] input1_monitor_o,
    input wire logic signed [15:0] input2_monitor_o,
    input wire logic signed [15:0] input3_monitor_o,
    input wire aic_out_t input1_result_o,
    input wire aic_out_t input2_result_o,
    input wire logic filter_step_o
);
    // ----------
    // slot tracking
    // ----------
    logic [1:0] slot, next_slot;
    logic [15:0] gap, next_gap;
    logic seen, next_seen;
    wire logic u1 = input1_cfg_i.gain == 16'h03e8 && input1_cfg_i.offset == 16'sh0000;
    wire logic u2 = input2_cfg_i.gain == 16'h03e8 && input2_cfg_i.offset == 16'sh0000;
    wire logic u3 = input3_cfg_i.gain == 16'h03e8 && input3_cfg_i.offset == 16'sh0000;
    wire logic signed [15:0] mag1 = input1_monitor_o[15] ? -input1_monitor_o : input1_monitor_o;
    always_comb begin
        next_slot = rst_i ? 2'h0 : slot + {1'b0, filter_step_o};
        next_gap = (rst_i || filter_step_o) ? 16'h0000 : gap + 16'h0001;
        next_seen = !rst_i && (seen || filter_step_o);
    end
    always_ff @(posedge sys_clk_i) begin
        slot <= next_slot;
        gap <= next_gap;
        seen <= next_seen;
    end
    // ----------
    // properties
    // ----------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_direct_slot;
        filter_step_o && slot == 2'h0 && input1_cfg_i.filter_time == 16'h0000
            && input1_cfg_i.func == AIC_FUNC_SPEED;
    endsequence
    a_hold_idle: assert property (
        !sample_valid_i |=> $stable(input1_monitor_o)) else $error("monitor moved idle");
    a_unity_pass: assert property (
        sample_valid_i && u1 && input1_cfg_i.signal_type == 3'h0
        |=> input1_monitor_o == $past(analog_in_one_i)) else $error("unity path off");
    a_inv_map: assert property (
        sample_valid_i && u2 && input2_cfg_i.signal_type == 3'h2 && !analog_in_two_i[15]
        |=> input2_monitor_o == 16'sh2710 - $past(analog_in_two_i)) else $error("inverse off");
    a_live_zero: assert property (
        sample_valid_i && u3 && input3_cfg_i.signal_type == 3'h1
        && analog_in_three_i == 16'sh07d0 |=> input3_monitor_o == 16'sh0000)
        else $error("live zero off");
    a_bipolar_two: assert property (
        sample_valid_i && u2 && input2_cfg_i.signal_type == 3'h4
        |=> input2_monitor_o == $past(analog_in_two_i)) else $error("bipolar off");
    a_sat_top: assert property (
        sample_valid_i && input1_cfg_i.gain == 16'h270f && input1_cfg_i.offset == 16'sh0000
        && input1_cfg_i.signal_type == 3'h0 && analog_in_one_i == 16'sh2710
        |=> input1_monitor_o == 16'sh2710) else $error("no saturation");
    a_speed_reverse: assert property (
        s_direct_slot |-> ##2 input1_result_o.value == $past(mag1, 2)
        && input1_result_o.reverse == $past(input1_monitor_o[15], 2))
        else $error("speed result off");
    a_torque_floor: assert property (
        input2_cfg_i.func == AIC_FUNC_TORQUE |=> !input2_result_o.value[15])
        else $error("torque negative");
    a_step_spacing: assert property (
        filter_step_o && seen |-> gap == 16'(SLOT_CYCLES - 1)) else $error("step spacing off");
endmodule // aic_top_monitor

bind aic_top aic_top_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) u_aic_top_monitor (.*);

// *** test/aic_adc_model.sv ***
/*
 * Converter model giving four samples with a valid strobe.
 * Assumes the bench calls present() after a clock edge.
 */
`timescale 1ns/1ps

module aic_adc_model (
    input wire logic sys_clk_i,
    output logic sample_valid_o,
    output logic signed [15:0] ch1_o,
    output logic signed [15:0] ch2_o,
    output logic signed [15:0] ch3_o,
    output logic signed [15:0] ch4_o
);
    // ----------
    // delivery
    // ----------
    initial begin
        sample_valid_o = 1'b0;
        {ch1_o, ch2_o, ch3_o, ch4_o} = 64'h0;
    end
    // released lines show the inverse so stale data never looks valid
    task automatic present(int idle, logic signed [15:0] a, b, c, d);
        repeat (idle + 1) @(posedge sys_clk_i);
        #1;
        sample_valid_o = 1'b1;
        {ch1_o, ch2_o, ch3_o, ch4_o} = {a, b, c, d};
        @(posedge sys_clk_i);
        #1;
        sample_valid_o = 1'b0;
        {ch1_o, ch2_o, ch3_o, ch4_o} = ~{a, b, c, d};
    endtask
endmodule // aic_adc_model

// *** test/tb_aic_top.sv ***
/*
 * Self-checking bench of the conditioning block.
 * Assumes SLOT_CYCLES of 4 and the converter model.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %0d seen %0d", nm, e, g); end end

module tb_aic_top;
    import aic_pkg::*;
    logic sys_clk_i;
    logic rst_i;
    logic valid;
    logic step;
    logic signed [15:0] x1, x2, x3, x4, m1, m2, m3, m4;
    aic_cfg_t c1, c2, c3, c4;
    aic_out_t r1, r2, r3, r4;
    int n_mismatch;
    int n_tests;

    aic_adc_model u_aic_adc_model (.sys_clk_i(sys_clk_i), .sample_valid_o(valid),
        .ch1_o(x1), .ch2_o(x2), .ch3_o(x3), .ch4_o(x4));
    aic_top #(.SLOT_CYCLES(4)) u_aic_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .sample_valid_i(valid), .analog_in_one_i(x1), .analog_in_two_i(x2),
        .analog_in_three_i(x3), .analog_in_four_i(x4), .input1_cfg_i(c1), .input2_cfg_i(c2),
        .input3_cfg_i(c3), .input4_cfg_i(c4), .input1_monitor_o(m1), .input2_monitor_o(m2),
        .input3_monitor_o(m3), .input4_monitor_o(m4), .input1_result_o(r1),
        .input2_result_o(r2), .input3_result_o(r3), .input4_result_o(r4), .filter_step_o(step));

    // ----------
    // helpers
    // ----------
    function automatic aic_cfg_t mk(int g, int o, int ft, int t, int f);
        return '{16'(g), 16'(o), 16'(ft), 3'(t), 3'(f)};
    endfunction
    function automatic logic signed [15:0] expv(int t, int x);
        int v;
        v = t == 1 ? (x - 2000) * 5 / 4 : t == 2 ? 10000 - x : t == 3 ? 10000 - (x - 2000) * 5 / 4 : x;
        return 16'(v > 10000 ? 10000 : v < -10000 ? -10000 : v);
    endfunction
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
    endtask
    task automatic wait_steps(int n);
        int k;
        k = 0;
        for (int i = 0; i < 100 && k < n; i++) begin
            @(posedge sys_clk_i);
            #1;
            k += int'(step === 1'b1);
        end
        `CHK("steps", n, k)
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_math();
        c1 = mk(1000, -7000, 0, 0, 0);
        c2 = mk(2000, 1000, 0, 0, 0);
        c3 = mk(9999, 0, 0, 0, 0);
        c4 = c3;
        u_aic_adc_model.present(0, 5000, 3000, 10000, -10000);
        `CHK("monitor1", 16'shf830, m1)
        `CHK("monitor2", 16'sh1f40, m2)
        `CHK("monitor3", 16'sh2710, m3)
        `CHK("monitor4", 16'shd8f0, m4)
        c1 = c3;
        u_aic_adc_model.present(3, 10000, 0, 0, 0);
        `CHK("monitor1", 16'sh2710, m1)
    endtask
    task automatic t_types();
        for (int t = 0; t < 5; t++) begin
            c1 = mk(1000, 0, 0, t, 0);
            c2 = c1;
            c3 = c1;
            c4 = c1;
            u_aic_adc_model.present(0, 7000, t == 4 ? -4000 : 7000, 2000, t == 4 ? -4000 : 0);
            `CHK("monitor1", expv(t, 7000), m1)
            `CHK("monitor2", expv(t, t == 4 ? -4000 : 7000), m2)
            `CHK("monitor3", expv(t, 2000), m3)
            `CHK("monitor4", expv(t, t == 4 ? -4000 : 0), m4)
        end
    endtask
    task automatic t_filter();
        do_reset();
        c1 = mk(1000, 0, 0, 0, 0);
        c2 = mk(1000, 0, 0, 0, 2);
        c3 = mk(1000, 0, 1, 0, 3);
        c4 = mk(1000, 0, 0, 0, 3);
        wait_steps(4);
        u_aic_adc_model.present(0, -2000, -3000, 5000, 4000);
        wait_steps(4);
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK("result1", 16'sh07d0, r1.value)
        `CHK("reverse1", 1'b1, r1.reverse)
        `CHK("result2", 16'sh0000, r2.value)
        `CHK("reverse2", 1'b0, r2.reverse)
        `CHK("result3", 16'sh01f4, r3.value)
        `CHK("result4", 16'sh0fa0, r4.value)
        wait_steps(4);
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK("result3", 16'sh03b6, r3.value)
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // tests take about 80 cycles; wide margin
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst_i = 1'b1;
        c1 = mk(1000, 0, 0, 0, 0);
        c2 = c1;
        c3 = c1;
        c4 = c1;
        do_reset();
        t_math();
        t_types();
        t_filter();
        end_of_test();
    end
endmodule // tb_aic_top
